// *** dmx_exec.sv ***
// Purpose: executes the data-move and control instruction group
// Assumes: one instruction word per clock, data memory outside
// Notes:   writes to memory leave as a registered strobe
//
// Behaviour
// - load-bank puts its literal in the bank select register, no flags
// - load-page puts its seven-bit literal in the pc high latch, no flags
// - load-working puts its eight-bit literal in W, one word, one cycle
// - store-working writes W to the 7-bit addressed file register, one cycle
// - indirect address is pointer (post modes), pointer +1, -1, or plus signed offset -32..31
// - pointer ends +1 for increments, -1 for decrements, same for offset
// - mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec; one bit picks
// - access port has no storage; it reaches the pointed-to location
// - pointer spans 000h to FFFh and wraps both ways
// - pointer updates and indirect stores leave status untouched
// - load-option copies W into the option register, no flags
// - software reset resets the device and clears the reset flag
`timescale 1ns/1ps
`include "dmx_exec_cfg.svh"

module dmx_exec
    import dmx_exec_pkg::*;
(
    input  wire logic          ref_clk_in,
    input  wire logic          nrst_in,
    input  wire dmx_instr_type instr_in,
    input  wire logic          reset_flag_set_in,
    output logic [7:0]         working_reg_out,
    output logic [4:0]         bank_select_reg_out,
    output logic [6:0]         pc_high_latch_out,
    output logic [7:0]         option_reg_out,
    output logic [11:0]        indirect_pointer0_out,
    output logic [11:0]        indirect_pointer1_out,
    output dmx_wr_type         mem_wr_out,
    output logic               reset_instr_flag_out,
    output logic               sw_reset_out
);

    logic        rst_meta;
    logic        rst_n;
    logic [7:0]  work;
    logic [4:0]  bank;
    logic [6:0]  page;
    logic [7:0]  option;
    logic [11:0] ptr0;
    logic [11:0] ptr1;
    logic        flag;
    logic        sw_rst;
    dmx_wr_type  wr;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // decode
    wire [13:0] w = instr_in.word;
    wire v = instr_in.valid;
    dmx_op_type op;
    assign op = !v ? DMX_NONE :
        (w == `DMX_OP_NOP)                      ? DMX_NOP    :
        (w == `DMX_OP_SWRST)                    ? DMX_SWRST  :
        (w == `DMX_OP_OPTION)                   ? DMX_OPTION :
        ((w & `DMX_MSK_BANK) == `DMX_PAT_BANK)  ? DMX_BANK   :
        ((w & `DMX_MSK_PAGE) == `DMX_PAT_PAGE)  ? DMX_PAGE   :
        ((w & `DMX_MSK_LIT) == `DMX_PAT_LIT)    ? DMX_LIT    :
        ((w & `DMX_MSK_FILE) == `DMX_PAT_FILE)  ? DMX_FILE   :
        ((w & `DMX_MSK_IND) == `DMX_PAT_IND)    ? DMX_IND    :
        ((w & `DMX_MSK_REL) == `DMX_PAT_REL)    ? DMX_REL    :
                                                  DMX_NONE;

    // a direct store to a port address is redirected through its pointer
    wire        f_port0 = (w[6:0] == `DMX_PORT0_ADDR);
    wire        f_port1 = (w[6:0] == `DMX_PORT1_ADDR);
    wire [11:0] file_addr = f_port0 ? ptr0 :
                            f_port1 ? ptr1 :
                            {bank, w[6:0]};

    wire        sel_n  = (op == DMX_REL) ? w[`DMX_REL_N_BIT]
                                         : w[`DMX_IND_N_BIT];
    wire [1:0]  mode   = w[1:0];
    wire [11:0] ptr    = sel_n ? ptr1 : ptr0;
    // 12-bit sums wrap at both ends; no carry or zero result leaves here
    wire [11:0] ptr_inc = 12'(ptr + `DMX_PTR_ONE);
    wire [11:0] ptr_dec = 12'(ptr - `DMX_PTR_ONE);
    wire [11:0] ptr_rel = 12'(ptr + {{6{w[5]}}, w[5:0]});
    wire        is_inc  = ~mode[0];
    wire        is_pre  = ~mode[1];
    wire [11:0] ind_ea  = (op == DMX_REL) ? ptr_rel :
                          !is_pre ? ptr :
                          is_inc ? ptr_inc : ptr_dec;
    wire [11:0] ind_new = (op == DMX_REL) ? ptr :
                          is_inc ? ptr_inc : ptr_dec;
    wire        ptr_upd = (op == DMX_IND) || (op == DMX_REL);

    wire [11:0] next_ptr0 = (ptr_upd && !sel_n) ? ind_new : ptr0;
    wire [11:0] next_ptr1 = (ptr_upd && sel_n)  ? ind_new : ptr1;

    // one assignment for the whole strobe word keeps a single driver
    dmx_wr_type next_wr;
    assign next_wr = '{valid: (op == DMX_FILE) || ptr_upd,
                       addr:  (op == DMX_FILE) ? file_addr : ind_ea,
                       data:  work};

    wire [7:0] next_work   = (op == DMX_LIT)    ? w[7:0] : work;
    wire [4:0] next_bank   = (op == DMX_BANK)   ? w[4:0] : bank;
    wire [6:0] next_page   = (op == DMX_PAGE)   ? w[6:0] : page;
    wire [7:0] next_option = (op == DMX_OPTION) ? work   : option;
    wire       do_swrst    = (op == DMX_SWRST);

    // the flag lives outside the software reset so it can report one;
    // the software reset's clear beats a reset_flag_set_in set landing in the same cycle
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b1;
        end else if (do_swrst) begin
            flag <= 1'b0;
        end else if (reset_flag_set_in) begin
            flag <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            work   <= `DMX_RST_WORK;
            bank   <= `DMX_RST_BANK;
            page   <= `DMX_RST_PAGE;
            option <= `DMX_RST_OPTION;
            ptr0   <= `DMX_RST_PTR;
            ptr1   <= `DMX_RST_PTR;
            wr     <= '0;
            sw_rst <= 1'b0;
        end else if (do_swrst) begin
            work   <= `DMX_RST_WORK;
            bank   <= `DMX_RST_BANK;
            page   <= `DMX_RST_PAGE;
            option <= `DMX_RST_OPTION;
            ptr0   <= `DMX_RST_PTR;
            ptr1   <= `DMX_RST_PTR;
            wr     <= '0;
            sw_rst <= 1'b1;
        end else begin
            work   <= next_work;
            bank   <= next_bank;
            page   <= next_page;
            option <= next_option;
            ptr0   <= next_ptr0;
            ptr1   <= next_ptr1;
            wr     <= next_wr;
            sw_rst <= 1'b0;
        end
    end

    assign working_reg_out       = work;
    assign bank_select_reg_out   = bank;
    assign pc_high_latch_out     = page;
    assign option_reg_out        = option;
    assign indirect_pointer0_out = ptr0;
    assign indirect_pointer1_out = ptr1;
    assign mem_wr_out            = wr;
    assign reset_instr_flag_out  = flag;
    assign sw_reset_out          = sw_rst;

    a_bank_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_BANK |=> bank == $past(w[4:0]))
        else $error("bank select not loaded");

    a_page_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_PAGE |=> page == $past(w[6:0]) && !sw_rst)
        else $error("pc high latch not loaded");

    a_lit_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_LIT |=> work == $past(w[7:0]) && !wr.valid)
        else $error("working register not loaded in one cycle");

    a_file_store: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_FILE && !f_port0 && !f_port1 |=> wr.valid
        && wr.addr == {$past(bank), $past(w[6:0])}
        && wr.data == $past(work))
        else $error("direct store wrong");

    a_port_redirect: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_FILE && f_port1 |=> wr.addr == $past(ptr1))
        else $error("port store not redirected");

    a_pre_addr: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_IND && mode == 2'b01 && !sel_n
        |=> wr.valid && wr.addr == 12'($past(ptr0) - 12'h001)
        && ptr0 == wr.addr)
        else $error("pre-decrement address wrong");

    a_post_inc: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_IND && mode == 2'b10 && sel_n
        |=> wr.addr == $past(ptr1)
        && ptr1 == 12'($past(ptr1) + 12'h001))
        else $error("post-increment wrong");

    a_rel_keep: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_REL |=> $stable(ptr0) && $stable(ptr1))
        else $error("relative store moved a pointer");

    a_ptr_wrap: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_IND && mode == 2'b00 && !sel_n && ptr0 == 12'hFFF
        |=> ptr0 == 12'h000)
        else $error("pointer did not wrap");

    a_option_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_OPTION |=> option == $past(work))
        else $error("option register not loaded");

    a_soft_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        do_swrst |=> sw_rst && !flag && option == `DMX_RST_OPTION
        ##1 (!sw_rst || $past(do_swrst)))
        else $error("software reset misbehaved");

    a_nop_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        op == DMX_NOP |=> $stable(work) && $stable(ptr0) && $stable(ptr1)
        && $stable(bank) && $stable(option) && $stable(page)
        && !wr.valid)
        else $error("no-operation changed state");

endmodule

// *** dmx_exec_cfg.svh ***
// Purpose: constants for the data-move instruction executor
// Assumes: 14-bit instruction words, one instruction per clock
// Notes:   opcode patterns are matched as (word & mask) == pattern
`ifndef DMX_EXEC_CFG_SVH
`define DMX_EXEC_CFG_SVH

`define DMX_OP_NOP        14'h0000
`define DMX_OP_SWRST      14'h0001
`define DMX_OP_OPTION     14'h0062
`define DMX_MSK_BANK      14'h3FE0
`define DMX_PAT_BANK      14'h0020
`define DMX_MSK_IND       14'h3FF8
`define DMX_PAT_IND       14'h0018
`define DMX_MSK_REL       14'h3F80
`define DMX_PAT_REL       14'h3F80
`define DMX_MSK_PAGE      14'h3F80
`define DMX_PAT_PAGE      14'h3180
`define DMX_MSK_LIT       14'h3F00
`define DMX_PAT_LIT       14'h3000
`define DMX_MSK_FILE      14'h3F80
`define DMX_PAT_FILE      14'h0080

`define DMX_IND_N_BIT     2
`define DMX_REL_N_BIT     6
`define DMX_PORT0_ADDR    7'h00
`define DMX_PORT1_ADDR    7'h01

`define DMX_RST_WORK      8'h00
`define DMX_RST_BANK      5'h00
`define DMX_RST_PAGE      7'h00
`define DMX_RST_OPTION    8'hFF
`define DMX_RST_PTR       12'h000
`define DMX_PTR_ONE       12'h001

`endif

// *** dmx_exec_pkg.sv ***
// Purpose: types shared by the data-move instruction executor
// Assumes: constants come from dmx_exec_cfg.svh
// Notes:   op class codes are one-hot apart from the all-zero DMX_NONE
package dmx_exec_pkg;

    typedef struct packed {
        logic        valid;
        logic [13:0] word;
    } dmx_instr_type;

    typedef struct packed {
        logic        valid;
        logic [11:0] addr;
        logic [7:0]  data;
    } dmx_wr_type;

    typedef enum logic [8:0] {
        DMX_NONE   = 9'b0_0000_0000,
        DMX_NOP    = 9'b0_0000_0001,
        DMX_SWRST  = 9'b0_0000_0010,
        DMX_OPTION = 9'b0_0000_0100,
        DMX_BANK   = 9'b0_0000_1000,
        DMX_PAGE   = 9'b0_0001_0000,
        DMX_LIT    = 9'b0_0010_0000,
        DMX_FILE   = 9'b0_0100_0000,
        DMX_IND    = 9'b0_1000_0000,
        DMX_REL    = 9'b1_0000_0000
    } dmx_op_type;

endpackage

// *** tb.sv ***
// Purpose: self-checking bench for the data-move instruction executor
// Assumes: results show at the edge that takes the word and are read half a clock later
// Notes:   inputs move and outputs are read on the falling edge
`timescale 1ns/1ps
`include "dmx_exec_cfg.svh"

module tb import dmx_exec_pkg::*;;
    logic          ref_clk_in;
    logic          nrst_in;
    logic          reset_flag_set_in;
    dmx_instr_type instr_in;
    logic [7:0]    working_reg_out;
    logic [4:0]    bank_select_reg_out;
    logic [6:0]    pc_high_latch_out;
    logic [7:0]    option_reg_out;
    logic [11:0]   indirect_pointer0_out;
    logic [11:0]   indirect_pointer1_out;
    dmx_wr_type    mem_wr_out;
    logic          reset_instr_flag_out;
    logic          sw_reset_out;
    int            n_mismatch;
    int            n_checks;
    logic [13:0]   ind_word [4];
    logic [11:0]   ind_addr [4];
    logic [11:0]   ind_p0   [4];
    logic [11:0]   ind_p1   [4];

    dmx_exec u_dut (
        .ref_clk_in            (ref_clk_in),
        .nrst_in               (nrst_in),
        .instr_in              (instr_in),
        .reset_flag_set_in     (reset_flag_set_in),
        .working_reg_out       (working_reg_out),
        .bank_select_reg_out   (bank_select_reg_out),
        .pc_high_latch_out     (pc_high_latch_out),
        .option_reg_out        (option_reg_out),
        .indirect_pointer0_out (indirect_pointer0_out),
        .indirect_pointer1_out (indirect_pointer1_out),
        .mem_wr_out            (mem_wr_out),
        .reset_instr_flag_out  (reset_instr_flag_out),
        .sw_reset_out          (sw_reset_out)
    );

    initial ref_clk_in = 1'b0;
    always #12.5 ref_clk_in = ~ref_clk_in;

    task automatic chk(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_wr(input dmx_wr_type exp);
        n_checks++;
        if (mem_wr_out !== exp) begin
            n_mismatch++;
            $display("BAD mem_wr expected %h seen %h", exp, mem_wr_out);
        end
    endtask

    // one instruction, then idle; results are visible on return
    task automatic exec(input logic [13:0] w);
        @(negedge ref_clk_in);
        instr_in = '{valid: 1'b1, word: w};
        @(negedge ref_clk_in);
        instr_in = '0;
    endtask

    task automatic regs(input logic [7:0] w, input logic [7:0] opt,
                        input logic [4:0] bank, input logic [6:0] page);
        chk("working", {4'h0, w}, {4'h0, working_reg_out});
        chk("option", {4'h0, opt}, {4'h0, option_reg_out});
        chk("bank", {7'h00, bank}, {7'h00, bank_select_reg_out});
        chk("page", {5'h00, page}, {5'h00, pc_high_latch_out});
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // the whole sequence needs under a hundred clocks
    initial begin
        repeat (2000) @(posedge ref_clk_in);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        ind_word = '{14'h0019, 14'h0018, 14'h001E, 14'h001F};
        ind_addr = '{12'hFFF, 12'h000, 12'h000, 12'h001};
        ind_p0   = '{12'hFFF, 12'h000, 12'h000, 12'h000};
        ind_p1   = '{12'h000, 12'h000, 12'h001, 12'h000};
        n_mismatch = 0;
        n_checks = 0;
        nrst_in = 1'b0;
        reset_flag_set_in = 1'b0;
        instr_in = '0;
        repeat (4) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        nrst_in = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        regs(8'h00, 8'hFF, 5'h00, 7'h00);
        chk("flag", 12'h001, {11'h000, reset_instr_flag_out});
        $display("test reset_values done");
        exec(14'h002F);
        exec(14'h31FF);
        // back-to-back: the store must see the freshly loaded W
        @(negedge ref_clk_in);
        instr_in = '{valid: 1'b1, word: 14'h30A5};
        @(negedge ref_clk_in);
        instr_in = '{valid: 1'b1, word: 14'h00A5};
        chk("working", 12'h0A5, {4'h0, working_reg_out});
        @(negedge ref_clk_in);
        instr_in = '0;
        chk_wr('{1'b1, 12'h7A5, 8'hA5});
        @(negedge ref_clk_in);
        chk("wr_valid", 12'h000, {11'h000, mem_wr_out.valid});
        regs(8'hA5, 8'hFF, 5'h0F, 7'h7F);
        $display("test literals_and_file done");
        for (int i = 0; i < 4; i++) begin
            exec(ind_word[i]);
            chk_wr('{1'b1, ind_addr[i], 8'hA5});
            chk("ptr0", ind_p0[i], indirect_pointer0_out);
            chk("ptr1", ind_p1[i], indirect_pointer1_out);
        end
        exec(14'h3FE0);
        chk_wr('{1'b1, 12'hFE0, 8'hA5});
        chk("ptr1", 12'h000, indirect_pointer1_out);
        exec(14'h3F9F);
        chk_wr('{1'b1, 12'h01F, 8'hA5});
        chk("ptr0", 12'h000, indirect_pointer0_out);
        $display("test indirect done");
        exec(14'h001E);
        exec(14'h0081);
        chk_wr('{1'b1, 12'h001, 8'hA5});
        chk("ptr1", 12'h001, indirect_pointer1_out);
        exec(14'h0080);
        chk_wr('{1'b1, 12'h000, 8'hA5});
        exec(14'h0062);
        regs(8'hA5, 8'hA5, 5'h0F, 7'h7F);
        exec(14'h0000);
        regs(8'hA5, 8'hA5, 5'h0F, 7'h7F);
        chk("ptr1", 12'h001, indirect_pointer1_out);
        chk("wr_valid", 12'h000, {11'h000, mem_wr_out.valid});
        $display("test port_option_nop done");
        // a flag set in the reset cycle must lose to the reset's clear
        reset_flag_set_in = 1'b1;
        exec(14'h0001);
        reset_flag_set_in = 1'b0;
        chk("sw_reset", 12'h001, {11'h000, sw_reset_out});
        chk("flag", 12'h000, {11'h000, reset_instr_flag_out});
        regs(8'h00, 8'hFF, 5'h00, 7'h00);
        chk("ptr1", 12'h000, indirect_pointer1_out);
        @(negedge ref_clk_in);
        chk("sw_reset", 12'h000, {11'h000, sw_reset_out});
        reset_flag_set_in = 1'b1;
        @(negedge ref_clk_in);
        reset_flag_set_in = 1'b0;
        chk("flag", 12'h001, {11'h000, reset_instr_flag_out});
        $display("test software_reset done");
        print_verdict();
    end
endmodule
